//--- rtl/protected_register_write_guard.sv
// write guard for the power save and processor clock control registers
//
// Overview of operation
// R1 - protected write only via unlock sequence
// R2 - any byte written to unlock arms
// R3 - armed write may be store or bit-op
// R4 - reads need no unlock, keep guard
// R5 - interrupt or dma between drops write
// R6 - software masks interrupts around the sequence
// R7 - software halts dma during the sequence
// R8 - software inserts two or five nops
// R9 - instructions after power-save store still run
// R10 - unlock register write-only byte at fffff170
// R11 - status register resets 00, bit 4
// R12 - illegal store sets protection error flag
// R13 - exactly power save and clock guarded
// R14 - protected write without unlock sets error
// R15 - unlock then other store sets error
// R16 - error flag cleared by zero or reset
// R17 - armed state consumed by next store
//
// Strobed register access was decided locally.

`include "guard_map.svh"

module protected_register_write_guard (
  input  wire logic                 sys_clk,          // system clock, 25 MHz
  input  wire logic                 nrst,             // asynchronous reset, active low
  input  wire logic                 ce,               // clock enable, freezes all state when low
  input  wire logic [31:0]          addr,             // byte address of the access
  input  wire logic [7:0]           wdata,            // store data, or bit number for bit ops
  input  wire guard_pkg::store_op_t wr_op,            // kind of store
  input  wire logic                 wr,               // write strobe, one cycle
  input  wire logic                 rd,               // read strobe, one cycle
  input  wire logic                 serviced,         // interrupt or dma taken this cycle
  input  wire logic                 wake,             // wake event ends the power-save mode
  output logic      [7:0]           rdata,            // read data, cycle after rd
  output logic                      irq,              // level interrupt
  output logic      [7:0]           power_save_ctl,   // power save control contents
  output logic      [7:0]           clock_ctl,        // processor clock control contents
  output logic      [1:0]           power_save_req    // {idle, stop} request to the clock unit
);
  import guard_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic       armed;      // last store was to the unlock register, no service since
    logic       prot_err;   // sticky protection error
    logic [7:0] power_save_control_register;        // power save control
    logic [7:0] processor_clock_control_register;        // processor clock control
    logic [1:0] evt;        // sticky interrupt events
    logic [1:0] mask;       // interrupt mask
    logic [7:0] rdata;      // read data register
    logic       irq;        // interrupt output register
    logic [1:0] ps_req;     // power-save request output
    logic       ps_pend;    // power-save store waiting to take effect
    logic [2:0] ps_cnt;     // cycles left before it does
  } guard_state_t;

  guard_state_t st;         // current state
  guard_state_t next_st;    // next state

  // reset image of the status byte; only the flag bit of it is stored
  localparam logic [7:0] sys_rst_img = `RST_SYSTEM_STATUS;

  // ****************************************
  // address decode
  // ****************************************
  logic hit_sys;            // system status register
  logic hit_unlock;         // unlock command register
  logic hit_psc;            // power save control
  logic hit_pcc;            // processor clock control
  logic hit_prot;           // one of the two guarded registers
  logic hit_ists;           // interrupt status
  logic hit_imask;          // interrupt mask
  logic eff_armed;          // armed and not broken by a service
  logic accept;             // guarded write goes through
  logic err_set;            // illegal store seen this cycle
  logic err_clr;            // software writes zero to the flag
  logic [7:0] sys_val;      // status register after the store

  assign hit_sys    = (addr == `ADDR_SYSTEM_STATUS);
  assign hit_unlock = (addr == `ADDR_UNLOCK_COMMAND);   // R10
  assign hit_psc    = (addr == `ADDR_POWER_SAVE_CTL);
  assign hit_pcc    = (addr == `ADDR_CLOCK_CTL);
  assign hit_prot   = hit_psc | hit_pcc;                // R13
  assign hit_ists   = (addr == `ADDR_IRQ_STATUS);
  assign hit_imask  = (addr == `ADDR_IRQ_MASK);

  // a service in the same cycle as the guarded store counts as in between
  assign eff_armed  = st.armed & ~serviced;             // R5

  // ****************************************
  // store helpers
  // ****************************************
  // applies a plain store or a bit set, clear or invert to a byte
  function automatic logic [7:0] apply_op(
    input logic [7:0] old,
    input store_op_t  op,
    input logic [7:0] data
  );
    logic [7:0] bitsel;
    bitsel = 8'h01 << data[2:0];
    case (op)
      op_store:  apply_op = data;
      op_set:    apply_op = old | bitsel;
      op_clear:  apply_op = old & ~bitsel;
      op_invert: apply_op = old ^ bitsel;
      default:   apply_op = data;
    endcase
  endfunction : apply_op

  // status image seen by a bit op: only the flag bit lives
  assign sys_val = apply_op({3'h0, st.prot_err, 4'h0}, wr_op, wdata);

  // guarded write only right after the unlock write
  assign accept  = wr & hit_prot & eff_armed;                    // R1 R3

  // both illegal cases of the sequence
  assign err_set = (wr & hit_prot & ~eff_armed) |                // R12 R14
                   (wr & ~hit_prot & eff_armed);                 // R15

  // a zero reaching the flag bit clears it
  assign err_clr = wr & hit_sys & ~sys_val[`SYS_ERR_BIT];        // R16

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [1:0] evt_new;
    logic [7:0] rd_val;
    logic [7:0] mask_val;
    evt_new  = 2'h0;
    rd_val   = 8'h00;
    mask_val = 8'h00;
    next_st = st;

    // guard: every store consumes it, only unlock writes set it
    if (wr) begin
      next_st.armed = hit_unlock;                                // R2 R17
    end else if (serviced) begin
      next_st.armed = 1'b0;                                      // R5
    end

    // sticky flag, a new error wins over a clear in the same cycle
    if (err_clr) begin
      next_st.prot_err = 1'b0;                                   // R16
    end
    if (err_set) begin
      next_st.prot_err = 1'b1;                                   // R12
    end

    // guarded registers, either store form
    if (accept && hit_psc) begin
      next_st.power_save_control_register     = apply_op(st.power_save_control_register, wr_op, wdata);          // R3
      next_st.ps_pend = 1'b1;                                    // R9
      next_st.ps_cnt  = `PS_DELAY_CYCLES;
      next_st.ps_req  = 2'h0;
    end
    if (accept && hit_pcc) begin
      next_st.processor_clock_control_register = apply_op(st.processor_clock_control_register, wr_op, wdata);              // R3
    end

    // power-save mode waits so the following instructions still run
    if (st.ps_pend && !(accept && hit_psc)) begin
      if (st.ps_cnt <= 3'h1) begin
        next_st.ps_pend = 1'b0;
        next_st.ps_req  = {st.power_save_control_register[`PSC_IDLE_BIT], st.power_save_control_register[`PSC_STOP_BIT]}; // R9
      end else begin
        next_st.ps_cnt = st.ps_cnt - 3'h1;
      end
    end

    // wake ends the mode and drops the request bits
    if (wake) begin
      next_st.ps_req               = 2'h0;
      next_st.ps_pend              = 1'b0;
      next_st.power_save_control_register[`PSC_STOP_BIT]   = 1'b0;
      next_st.power_save_control_register[`PSC_IDLE_BIT]   = 1'b0;
    end

    // interrupt mask, plain register
    // mask is two bits wide, so only the low pair of the result is kept
    mask_val = apply_op({6'h00, st.mask}, wr_op, wdata);
    if (wr && hit_imask) begin
      next_st.mask = mask_val[1:0];
    end

    // interrupt events; read of status clears, new events win
    evt_new[`EVT_ERR_BIT]    = err_set;
    evt_new[`EVT_ACCEPT_BIT] = accept;
    if (rd && hit_ists) begin
      next_st.evt = 2'h0;
    end
    next_st.evt = next_st.evt | evt_new;

    // read mux; reads leave the guard alone
    if (hit_sys) begin
      rd_val = {3'h0, st.prot_err, 4'h0};                       // R4 R11
    end else if (hit_psc) begin
      rd_val = st.power_save_control_register;                                           // R4
    end else if (hit_pcc) begin
      rd_val = st.processor_clock_control_register;                                           // R4
    end else if (hit_ists) begin
      rd_val = {6'h00, st.evt};
    end else if (hit_imask) begin
      rd_val = {6'h00, st.mask};
    end else if (hit_unlock) begin
      rd_val = `UNLOCK_READ_VALUE;                               // R10
    end else begin
      rd_val = 8'h00;
    end
    // data stands only in the cycle after the strobe
    next_st.rdata = rd ? rd_val : 8'h00;

    // level interrupt from the masked sticky bits
    next_st.irq = |(next_st.evt & next_st.mask);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.armed    <= 1'b0;
      st.prot_err <= sys_rst_img[`SYS_ERR_BIT];                  // R11
      st.power_save_control_register      <= `RST_POWER_SAVE_CTL;
      st.processor_clock_control_register      <= `RST_CLOCK_CTL;
      st.evt      <= 2'h0;
      st.mask     <= `RST_IRQ_MASK;
      st.rdata    <= 8'h00;
      st.irq      <= 1'b0;
      st.ps_req   <= 2'h0;
      st.ps_pend  <= 1'b0;
      st.ps_cnt   <= 3'h0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs, straight from the state register
  // ****************************************
  assign rdata          = st.rdata;
  assign irq            = st.irq;
  assign power_save_ctl = st.power_save_control_register;
  assign clock_ctl      = st.processor_clock_control_register;
  assign power_save_req = st.ps_req;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // unarmed guarded store leaves both registers untouched
  prot_reject_a: assert property ( // R1
    (ce && wr && hit_prot && !st.armed && !wake) |=> ($stable(st.power_save_control_register) && $stable(st.processor_clock_control_register)))
    else $error("guarded register changed without unlock");

  // any byte to the unlock register arms the guard
  unlock_arm_a: assert property ( // R2
    (ce && wr && hit_unlock) |=> st.armed)
    else $error("unlock write did not arm");

  // armed bit set reaches the clock register
  bit_op_a: assert property ( // R3
    (ce && wr && hit_pcc && st.armed && !serviced && wr_op == op_set)
      |=> st.processor_clock_control_register[$past(wdata[2:0])])
    else $error("armed bit set lost");

  // a read never moves the guard
  read_keep_a: assert property ( // R4
    (ce && rd && !serviced) |=> (st.armed == $past(st.armed)))
    else $error("read disturbed guard");

  // a service breaks the sequence and the write is dropped
  service_drop_a: assert property ( // R5
    (ce && st.armed && serviced && wr && hit_prot && !wake)
      |=> ($stable(st.power_save_control_register) && $stable(st.processor_clock_control_register) && st.prot_err))
    else $error("write after service not dropped");

  // flag image occupies bit 4 alone, one cycle after read
  sys_read_a: assert property ( // R11
    (ce && rd && hit_sys) |=> (rdata == {3'h0, $past(st.prot_err), 4'h0}))
    else $error("status read image wrong");

  // store to a guarded register without unlock raises the flag
  unarmed_err_a: assert property ( // R14
    (ce && wr && hit_prot && !st.armed) |=> st.prot_err)
    else $error("unarmed guarded write not flagged");

  // first store after unlock to another register raises the flag
  other_err_a: assert property ( // R15
    (ce && wr && !hit_prot && st.armed && !serviced) |=> st.prot_err)
    else $error("stray store after unlock not flagged");

  // zero written and nothing illegal clears the flag
  flag_clear_a: assert property ( // R16
    (ce && err_clr && !err_set) |=> !st.prot_err)
    else $error("flag not cleared by zero");

  // the next non-unlock store always disarms
  consume_a: assert property ( // R17
    (ce && wr && !hit_unlock) |=> !st.armed)
    else $error("guard not consumed");

  // power-save request stays low for the first four cycles after the store
  ps_delay_a: assert property ( // R9
    (ce && accept && hit_psc && !wake) |=> (power_save_req == 2'h0) [*4])
    else $error("power-save took effect too early");

  // armed plain store to power save control lands as written
  store_land_a: assert property ( // R3
    (ce && wr && hit_psc && st.armed && !serviced && wr_op == op_store && !wake)
      |=> (power_save_ctl == $past(wdata)))
    else $error("armed plain store lost");

  // a service alone breaks an armed guard
  service_disarm_a: assert property ( // R5
    (ce && serviced && !wr) |=> !st.armed)
    else $error("service left the guard armed");

  // stores to unguarded registers never raise the flag on their own
  plain_store_a: assert property ( // R13
    (ce && wr && !hit_prot && !st.armed) |=> !$rose(st.prot_err))
    else $error("unguarded store raised the flag");

  // an illegal store always leaves the flag set
  err_sticky_a: assert property ( // R12
    (ce && err_set) |=> st.prot_err)
    else $error("illegal store not flagged");

  // unlock reads return the fixed filler value
  unlock_read_a: assert property ( // R10
    (ce && rd && hit_unlock) |=> (rdata == `UNLOCK_READ_VALUE))
    else $error("unlock read value wrong");

  // ****************************************
  // covers
  // ****************************************
  cov_accept: cover property (ce && accept);
  cov_err: cover property (ce && err_set);
  cov_irq: cover property ($rose(irq));
  cov_ps: cover property ($rose(power_save_req[0]));
  cov_drop: cover property (ce && st.armed && serviced && wr && hit_prot);

endmodule : protected_register_write_guard

//--- rtl/guard_map.svh
// register offsets, field positions, reset values and timing counts of the write guard
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_SYSTEM_STATUS   32'hfffff078
`define ADDR_UNLOCK_COMMAND  32'hfffff170
`define ADDR_POWER_SAVE_CTL  32'hfffff0f0
`define ADDR_CLOCK_CTL       32'hfffff0f4
`define ADDR_IRQ_STATUS      32'hfffff0f8
`define ADDR_IRQ_MASK        32'hfffff0fc

// ****************************************
// field positions
// ****************************************
`define SYS_ERR_BIT          3'h4
`define PSC_STOP_BIT         3'h1
`define PSC_IDLE_BIT         3'h2
`define EVT_ERR_BIT          1'h0
`define EVT_ACCEPT_BIT       1'h1

// ****************************************
// reset values and the unlock read value
// ****************************************
`define RST_SYSTEM_STATUS    8'h00
`define RST_POWER_SAVE_CTL   8'h00
`define RST_CLOCK_CTL        8'h00
`define RST_IRQ_MASK         2'h0
`define UNLOCK_READ_VALUE    8'h00

// ****************************************
// timing counts
// ****************************************
// cycles between a power-save store and the mode taking effect
`define PS_DELAY_CYCLES      3'h5

`endif

//--- rtl/guard_pkg.sv
// types shared by the protected register write guard
package guard_pkg;

  // ****************************************
  // kind of store issued by the core
  // ****************************************
  typedef enum logic [1:0] {
    op_store,
    op_set,
    op_clear,
    op_invert
  } store_op_t;

endpackage : guard_pkg

//--- tb/core_store_model.sv
// core model issuing byte stores and reads on the peripheral bus
`include "guard_map.svh"
module core_store_model (
  input  wire logic          sys_clk,  // system clock
  input  wire logic [7:0]    rdata,    // read data from the guard
  output logic      [31:0]   addr,     // byte address
  output logic      [7:0]    wdata,    // store data or bit number
  output guard_pkg::store_op_t wr_op,  // kind of store
  output logic               wr,       // write strobe
  output logic               rd,       // read strobe
  output logic               serviced  // interrupt or dma taken
);
  timeunit 1ns;
  timeprecision 1ns;
  import guard_pkg::*;

  // quiet bus at time zero
  initial begin
    addr     = 32'h0;
    wdata    = 8'h00;
    wr_op    = op_store;
    wr       = 1'b0;
    rd       = 1'b0;
    serviced = 1'b0;
  end

  // ****************
  // bus cycles
  // ****************
  // one store; released lines show inverted junk, not the old value
  task automatic store(input logic [31:0] a, input logic [7:0] d, input store_op_t op);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_op <= op;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    @(negedge sys_clk);
  endtask : store

  // one read; data taken in the cycle after the strobe
  task automatic load(input logic [31:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(negedge sys_clk);
    d = rdata;
  endtask : load

  // unlock then guarded store; serviced stays low throughout
  task automatic guarded(input logic [31:0] a, input logic [7:0] d, input store_op_t op);
    store(`ADDR_UNLOCK_COMMAND, ~d, op_store);
    store(a, d, op);
    repeat (2) @(negedge sys_clk);
  endtask : guarded

  // one store with a service taken in the very same cycle
  task automatic serviced_store(input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr     <= a;
    wdata    <= d;
    wr_op    <= op_store;
    wr       <= 1'b1;
    serviced <= 1'b1;
    @(posedge sys_clk);
    wr       <= 1'b0;
    serviced <= 1'b0;
    addr     <= ~a;
    wdata    <= ~d;
    @(negedge sys_clk);
  endtask : serviced_store

  // one cycle of interrupt or dma service, only when a test asks
  task automatic service;
    @(posedge sys_clk);
    serviced <= 1'b1;
    @(posedge sys_clk);
    serviced <= 1'b0;
  endtask : service
endmodule : core_store_model

//--- tb/test_protected_register_write_guard.sv
// self-checking bench for the protected register write guard
`include "guard_map.svh"
module test_protected_register_write_guard;
  timeunit 1ns;
  timeprecision 1ns;
  import guard_pkg::*;

  localparam logic [31:0] psave_a = `ADDR_POWER_SAVE_CTL;
  localparam logic [31:0] pclk_a  = `ADDR_CLOCK_CTL;
  localparam logic [31:0] stat_a  = `ADDR_SYSTEM_STATUS;
  localparam logic [31:0] unlk_a  = `ADDR_UNLOCK_COMMAND;
  localparam logic [31:0] ist_a   = `ADDR_IRQ_STATUS;
  localparam logic [31:0] imsk_a  = `ADDR_IRQ_MASK;

  logic        sys_clk, nrst, ce, wake, wr, rd, serviced, irq;
  logic [31:0] addr;
  logic [7:0]  wdata, rdata, power_save_ctl, clock_ctl;
  logic [1:0]  power_save_req;
  store_op_t   wr_op;
  int          mismatches  = 0;
  int          comparisons = 0;

  core_store_model core (.sys_clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_op(wr_op), .wr(wr), .rd(rd), .serviced(serviced));
  protected_register_write_guard dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_op(wr_op), .wr(wr), .rd(rd), .serviced(serviced), .wake(wake),
    .rdata(rdata), .irq(irq), .power_save_ctl(power_save_ctl), .clock_ctl(clock_ctl),
    .power_save_req(power_save_req));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [31:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    core.load(a, d);
    chk(d, exp, what);
  endtask : rchk

  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    chk(clock_ctl, 8'h00, "clock ctl reset");
    rchk(stat_a, 8'h00, "status reset");
    rchk(unlk_a, `UNLOCK_READ_VALUE, "unlock read");
    rchk(32'hfffff000, 8'h00, "unmapped read");
    $display("done reset");
  endtask : t_reset

  // bare guarded stores are refused and flagged; zero clears
  task automatic t_bare;
    core.store(psave_a, 8'h02, op_store);
    chk(power_save_ctl, 8'h00, "bare store landed");
    rchk(stat_a, 8'h10, "flag after bare store");
    core.store(stat_a, 8'hef, op_store);
    rchk(stat_a, 8'h00, "flag clear by zero");
    $display("done bare");
  endtask : t_bare

  // any unlock byte arms; store and every bit op land
  task automatic t_unlock;
    logic [7:0] vals [3] = '{8'h00, 8'ha5, 8'hff};
    store_op_t  ops  [3] = '{op_clear, op_set, op_invert};
    logic [7:0] bits [3] = '{8'h03, 8'h03, 8'h00};
    logic [7:0] exps [3] = '{8'hf7, 8'hff, 8'hfe};
    foreach (vals[i]) begin
      core.guarded(pclk_a, vals[i], op_store);
      chk(clock_ctl, vals[i], "unlocked store");
    end
    foreach (ops[i]) begin
      core.guarded(pclk_a, bits[i], ops[i]);
      chk(clock_ctl, exps[i], "unlocked bit op");
    end
    rchk(stat_a, 8'h00, "no error flagged");
    $display("done unlock");
  endtask : t_unlock

  // reads need no unlock and leave the guard armed
  task automatic t_reads;
    rchk(pclk_a, 8'hfe, "clock ctl read");
    core.store(unlk_a, 8'h3c, op_store);
    rchk(stat_a, 8'h00, "status read while armed");
    core.store(pclk_a, 8'h11, op_store);
    chk(clock_ctl, 8'h11, "store after read");
    $display("done reads");
  endtask : t_reads

  // service between unlock and store drops the store
  task automatic t_service;
    core.store(unlk_a, 8'h00, op_store);
    core.service();
    core.store(pclk_a, 8'h22, op_store);
    chk(clock_ctl, 8'h11, "store after service");
    rchk(stat_a, 8'h10, "flag after service");
    core.store(stat_a, 8'h04, op_clear);
    rchk(stat_a, 8'h00, "flag clear by bit op");
    core.store(unlk_a, 8'h00, op_store);
    core.serviced_store(pclk_a, 8'h23);
    chk(clock_ctl, 8'h11, "store beside service");
    rchk(stat_a, 8'h10, "flag beside service");
    core.store(stat_a, 8'h00, op_store);
    rchk(stat_a, 8'h00, "flag clear by store");
    $display("done service");
  endtask : t_service

  // clock enable low freezes the guard and the clock register
  task automatic t_freeze;
    @(posedge sys_clk) ce <= 1'b0;
    core.guarded(pclk_a, 8'h99, op_store);
    chk(clock_ctl, 8'h11, "store while frozen");
    @(posedge sys_clk) ce <= 1'b1;
    rchk(stat_a, 8'h00, "no flag while frozen");
    $display("done freeze");
  endtask : t_freeze

  // system reset mid-run clears the flag and both registers
  task automatic t_rst;
    core.store(pclk_a, 8'h12, op_store);
    rchk(stat_a, 8'h10, "flag before reset");
    nrst = 1'b0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    chk(clock_ctl, 8'h00, "clock ctl after reset");
    chk(power_save_ctl, 8'h00, "power save after reset");
    rchk(stat_a, 8'h00, "flag after reset");
    $display("done reset run");
  endtask : t_rst

  // arming is spent by the very next store
  task automatic t_other;
    core.store(unlk_a, 8'h55, op_store);
    core.store(imsk_a, 8'h00, op_store);
    rchk(stat_a, 8'h10, "flag after other store");
    core.store(pclk_a, 8'h33, op_store);
    chk(clock_ctl, 8'h11, "store after spent unlock");
    core.guarded(pclk_a, 8'h44, op_store);
    core.store(pclk_a, 8'h55, op_store);
    chk(clock_ctl, 8'h44, "second store refused");
    core.store(stat_a, 8'h00, op_store);
    $display("done other");
  endtask : t_other

  // mode request waits while following instructions run
  task automatic t_power;
    core.store(unlk_a, 8'h01, op_store);
    core.store(psave_a, 8'h02, op_store);
    chk(power_save_ctl, 8'h02, "stop mode stored");
    repeat (4) begin
      @(negedge sys_clk);
      chk({6'h0, power_save_req}, 8'h00, "request too early");
    end
    @(negedge sys_clk);
    chk({6'h0, power_save_req}, 8'h01, "stop request");
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    @(negedge sys_clk);
    chk({6'h0, power_save_req}, 8'h00, "wake ends request");
    core.guarded(psave_a, 8'h04, op_store);
    repeat (4) @(negedge sys_clk);
    chk({6'h0, power_save_req}, 8'h02, "idle request");
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    $display("done power");
  endtask : t_power

  // interrupt raised, masked and cleared by status read
  task automatic t_irq;
    logic [7:0] d;
    core.load(ist_a, d);
    core.store(imsk_a, 8'h01, op_store);
    core.store(pclk_a, 8'h66, op_store);
    chk({7'h0, irq}, 8'h01, "irq on error");
    rchk(ist_a, 8'h01, "error event");
    chk({7'h0, irq}, 8'h00, "irq after read");
    core.store(imsk_a, 8'h02, op_store);
    core.guarded(pclk_a, 8'h77, op_store);
    chk({7'h0, irq}, 8'h01, "irq on accept");
    rchk(ist_a, 8'h02, "accept event");
    core.store(imsk_a, 8'h00, op_store);
    core.store(pclk_a, 8'h88, op_store);
    chk({7'h0, irq}, 8'h00, "masked irq");
    rchk(ist_a, 8'h01, "masked event kept");
    core.store(stat_a, 8'h00, op_store);
    rchk(stat_a, 8'h00, "flag cleared");
    $display("done irq");
  endtask : t_irq

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // main sequence; reset released away from the edge
  initial begin
    nrst = 1'b0;
    ce   = 1'b1;
    wake = 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_reset;
    t_bare;
    t_unlock;
    t_reads;
    t_freeze;
    t_service;
    t_other;
    t_power;
    t_irq;
    t_rst;
    end_sim;
  end

  // watchdog, well beyond the few hundred cycles used
  initial begin
    #(3000 * 40);
    mismatches++;
    $display("BAD at %0t ns: watchdog expired", $time);
    end_sim;
  end
endmodule : test_protected_register_write_guard
